// file: logic/pwd_fsm_pkg.sv
// package for the password protection command interpreter
// assumes a 32-bit classic wishbone slave and one 25 MHz clock
package pwd_fsm_pkg;
  // register byte offsets
  localparam logic [7:0] ADDR_CMD      = 8'h00; // write: command cycle address/data/lane
  localparam logic [7:0] ADDR_CTRL     = 8'h04; // lock word, bus width select
  localparam logic [7:0] ADDR_STATUS   = 8'h08; // status word and state
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h0C; // sticky events, read only
  localparam logic [7:0] ADDR_IRQ_CLR  = 8'h10; // write one to clear
  localparam logic [7:0] ADDR_IRQ_EN   = 8'h14; // interrupt enable
  localparam logic [7:0] ADDR_KEY_LO   = 8'h18; // stored key bits 31:0
  localparam logic [7:0] ADDR_KEY_HI   = 8'h1C; // stored key bits 63:32
  localparam logic [7:0] ADDR_RKEY_LO  = 8'h20; // supplied read key bits 31:0
  localparam logic [7:0] ADDR_RKEY_HI  = 8'h24; // supplied read key bits 63:32
  // command data values
  localparam logic [7:0] CMD_RESET     = 8'hF0;
  localparam logic [7:0] CMD_SR_READ   = 8'h70;
  localparam logic [7:0] CMD_SR_CLEAR  = 8'h71;
  localparam logic [7:0] CMD_UNLK_ENT  = 8'h25;
  localparam logic [7:0] CMD_UNLK_GO   = 8'h29;
  localparam logic [7:0] CMD_EXIT_ENT  = 8'h90;
  localparam logic [7:0] CMD_EXIT      = 8'h00;
  localparam logic [7:0] CMD_PROG      = 8'hA0;
  localparam logic [7:0] CMD_WCOUNT    = 8'h03;
  localparam logic [7:0] SR_HANG       = 8'h90;
  // field positions
  localparam int LR_RDPROT_BIT = 5;
  localparam int LR_PWMODE_BIT = 2;
  localparam int SR_READY_BIT  = 7;
  localparam int SR_PGERR_BIT  = 4;
  localparam int SR_SECV_BIT   = 1;
  localparam int LOW_ADDR_W    = 11; // address bits 10:0 checked at word count
  // key load cycle counts per bus width
  localparam int KEY_CYC_X16   = 4;
  localparam int KEY_CYC_X8    = 8;
  // event bits
  localparam int EV_DONE = 0;
  localparam int EV_HANG = 1;
  localparam int EV_PGE  = 2;
  localparam int EV_SECV = 3;
  localparam int EV_W    = 4;
  // timing
  localparam int CLK_HZ         = 25_000_000;
  localparam int T_PPB_US       = 100;  // protection program time, plain default
  localparam int T_VERIFY_NS    = 200;  // verify dwell, well inside the above
  localparam int T_BUSY_NS      = 200;  // brief ready drop on a violation
  localparam int T_PPB_CYC      = T_PPB_US * (CLK_HZ / 1_000_000);
  localparam int T_VERIFY_CYC   = (T_VERIFY_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int T_BUSY_CYC     = (T_BUSY_NS * (CLK_HZ / 1_000_000) + 999) / 1000;

  // machine states, gray along idle-entry-load-verify
  typedef enum logic [3:0] {
    ST_READ     = 4'h0,
    ST_IDLE     = 4'h1,
    ST_ENTRY    = 4'h3,
    ST_LOAD     = 4'h2,
    ST_VERIFY   = 4'h6,
    ST_HANG     = 4'h7,
    ST_PG_SETUP = 4'h5,
    ST_PG_BUSY  = 4'h4,
    ST_EXIT     = 4'hC,
    ST_PGE      = 4'hD,
    ST_VIOL     = 4'hF
  } pwd_state_e;

  // one command bus cycle
  typedef struct packed {
    logic [7:0]  byte_lane_select;
    logic [15:0] sector_addr;
    logic [15:0] low_addr;
    logic [15:0] data;
  } cmd_cycle_s;
endpackage

// file: logic/password_protection_command_fsm.sv
// password protection command interpreter with wishbone register access
// assumes a classic wishbone master on clk_i; commands are written as cycles to ADDR_CMD
// Operation
// [R1] error-free key programming returns the machine to password idle
// [R2] host loads key with four cycles on x16, eight on x8
// [R3] first load cycle sector address must equal the one given at entry
// [R4] later load cycles compare sector and lane to prior; mismatch means program error
// [R5] read protected when lock bits 5 and 2 clear and read key differs
// [R6] key mismatch at unlock start enters hang, status reads x90h
// [R7] verify state returns to idle well before the program time
// [R8] hang and program busy show ready bit 0, then 1 after program time
// [R9] programming with lock bit 2 clear drops ready briefly, idles, flags violation
// [R10] unlock start goes to verify only after the last word loaded
// [R11] host unlock: x25h, word count x03h, key words, then x29h at address 0; the code takes x29h at any low address
// [R12] idle: F0h to read, 90h then 00h exits, A0h programs if unprotected
//
// Added by the designer: the register offsets and the Wishbone register port.
module password_protection_command_fsm #(
  parameter int T_PPB_CYCLES = pwd_fsm_pkg::T_PPB_CYC
) (
  // clock, reset, enable
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  // wishbone slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  // device status
  output logic             ready_o,
  output logic             irq_o
);
  // elaboration check: the busy window must outlast the verify dwell
  if (T_PPB_CYCLES < pwd_fsm_pkg::T_VERIFY_CYC + 2) begin : g_bad_time
    $error("program time too short");
  end

  localparam int TW = $clog2(T_PPB_CYCLES + 1);

  pwd_fsm_pkg::pwd_state_e     state_ff;
  pwd_fsm_pkg::pwd_state_e     nxt_state;
  pwd_fsm_pkg::cmd_cycle_s     cmd;
  logic [7:0]                  lock_word_ff;
  logic                        bus_x8_ff;
  logic [63:0]                 secret_key_ff;
  logic [63:0]                 read_key_ff;
  logic [63:0]                 load_key_ff;
  logic [15:0]                 entry_sa_ff;
  logic [15:0]                 prev_sa_ff;
  logic [7:0]                  prev_lane_ff;
  logic [3:0]                  words_ff;
  logic [TW-1:0]               timer_ff;
  logic [pwd_fsm_pkg::EV_W-1:0] irq_stat_ff;
  logic [pwd_fsm_pkg::EV_W-1:0] irq_en_ff;
  logic [pwd_fsm_pkg::EV_W-1:0] ev;
  logic                        ack_ff;
  logic [31:0]                 dat_ff;
  logic                        req;
  logic                        cmd_wr;
  logic                        read_protect;
  logic                        last_word;
  logic [3:0]                  words_needed;

  //////////////////////////////////////////////////////////////////////////
  // helpers

  // true when the timer has reached its target
  function automatic logic timer_done(input logic [TW-1:0] t, input int target);
    return t >= TW'(target);
  endfunction

  assign req          = cyc_i && stb_i && !ack_ff && ce_i;
  assign cmd_wr       = req && we_i && adr_i == pwd_fsm_pkg::ADDR_CMD;
  assign cmd          = pwd_fsm_pkg::cmd_cycle_s'({sel_i[3:0], 4'h0, dat_i[31:16], 5'h00,
                        dat_i[26:16], dat_i[15:0]});
  // a key word whose low byte is 29h reads as the start command and cannot be loaded
  assign words_needed = bus_x8_ff ? 4'(pwd_fsm_pkg::KEY_CYC_X8) : 4'(pwd_fsm_pkg::KEY_CYC_X16); // R2
  assign last_word    = words_ff == words_needed;
  // lock bits 5 and 2 clear plus wrong read key
  assign read_protect = !lock_word_ff[pwd_fsm_pkg::LR_RDPROT_BIT] && // R5
                        !lock_word_ff[pwd_fsm_pkg::LR_PWMODE_BIT] && read_key_ff != secret_key_ff;

  //////////////////////////////////////////////////////////////////////////
  // command state machine

  // next state from the current command cycle; sector in bits 31:16, low addr from 26:16
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      pwd_fsm_pkg::ST_READ: begin
        nxt_state = state_ff;
      end
      pwd_fsm_pkg::ST_IDLE: begin
        if (cmd_wr) begin
          case (cmd.data[7:0])
            pwd_fsm_pkg::CMD_RESET:    nxt_state = pwd_fsm_pkg::ST_READ;     // R12
            pwd_fsm_pkg::CMD_EXIT_ENT: nxt_state = pwd_fsm_pkg::ST_EXIT;     // R12
            pwd_fsm_pkg::CMD_UNLK_ENT: begin
              if (cmd.low_addr == 16'h0000) nxt_state = pwd_fsm_pkg::ST_ENTRY; // R11
            end
            pwd_fsm_pkg::CMD_PROG: begin
              if (!read_protect) nxt_state = pwd_fsm_pkg::ST_PG_SETUP;       // R12
            end
            default: nxt_state = state_ff;
          endcase
        end
      end
      pwd_fsm_pkg::ST_ENTRY: begin
        if (cmd_wr) begin
          if (cmd.data[7:0] == pwd_fsm_pkg::CMD_WCOUNT && cmd.low_addr == 16'h0000) begin
            nxt_state = pwd_fsm_pkg::ST_LOAD;
          end else begin
            nxt_state = pwd_fsm_pkg::ST_PGE;
          end
        end
      end
      pwd_fsm_pkg::ST_LOAD: begin
        if (cmd_wr) begin
          if (cmd.data[7:0] == pwd_fsm_pkg::CMD_UNLK_GO && last_word) begin
            // R10
            nxt_state = (load_key_ff == secret_key_ff) ? pwd_fsm_pkg::ST_VERIFY
                                                       : pwd_fsm_pkg::ST_HANG; // R6
          end else if (last_word) begin
            nxt_state = pwd_fsm_pkg::ST_PGE;
          end else if (cmd.data[7:0] == pwd_fsm_pkg::CMD_UNLK_GO) begin
            // start with words still missing: the key is short, so the load is void
            nxt_state = pwd_fsm_pkg::ST_PGE; // R10
          end else if (words_ff == 4'h0 && cmd.sector_addr != entry_sa_ff) begin
            nxt_state = pwd_fsm_pkg::ST_PGE; // R3
          end else if (words_ff != 4'h0 && (cmd.sector_addr != prev_sa_ff ||
                       cmd.byte_lane_select != prev_lane_ff)) begin
            nxt_state = pwd_fsm_pkg::ST_PGE; // R4
          end
        end
      end
      pwd_fsm_pkg::ST_VERIFY: begin
        if (timer_done(timer_ff, pwd_fsm_pkg::T_VERIFY_CYC)) nxt_state = pwd_fsm_pkg::ST_IDLE; // R7
      end
      // hang leaves only by software reset, and only once the program time is over
      pwd_fsm_pkg::ST_HANG, pwd_fsm_pkg::ST_PG_BUSY: begin
        if (timer_done(timer_ff, T_PPB_CYCLES) && state_ff == pwd_fsm_pkg::ST_PG_BUSY) begin
          nxt_state = pwd_fsm_pkg::ST_IDLE; // R1
        end else if (timer_done(timer_ff, T_PPB_CYCLES) && cmd_wr &&
                     cmd.data[7:0] == pwd_fsm_pkg::CMD_RESET) begin
          nxt_state = pwd_fsm_pkg::ST_IDLE;
        end
      end
      // any command write confirms; the lock bit picks programming or a violation
      pwd_fsm_pkg::ST_PG_SETUP: begin
        if (cmd_wr) begin
          nxt_state = lock_word_ff[pwd_fsm_pkg::LR_PWMODE_BIT] ? pwd_fsm_pkg::ST_PG_BUSY
                                                             : pwd_fsm_pkg::ST_VIOL; // R9
        end
      end
      pwd_fsm_pkg::ST_VIOL: begin
        if (timer_done(timer_ff, pwd_fsm_pkg::T_BUSY_CYC)) nxt_state = pwd_fsm_pkg::ST_IDLE; // R9
      end
      pwd_fsm_pkg::ST_PGE: begin
        if (cmd_wr && cmd.data[7:0] == pwd_fsm_pkg::CMD_RESET) nxt_state = pwd_fsm_pkg::ST_IDLE;
      end
      pwd_fsm_pkg::ST_EXIT: begin
        if (cmd_wr && (cmd.data[7:0] == pwd_fsm_pkg::CMD_EXIT || cmd.data[7:0] == pwd_fsm_pkg::CMD_RESET)) begin
          nxt_state = pwd_fsm_pkg::ST_READ; // R12
        end else if (cmd_wr && cmd.data[7:0] == pwd_fsm_pkg::CMD_SR_READ) begin
          nxt_state = pwd_fsm_pkg::ST_IDLE;
        end
      end
      default: nxt_state = pwd_fsm_pkg::ST_IDLE;
    endcase
  end

  // state register; re-entry to the mode from read is by writing 90h at read
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_ff <= pwd_fsm_pkg::ST_IDLE;
    end else if (ce_i) begin
      if (state_ff == pwd_fsm_pkg::ST_READ && cmd_wr && cmd.data[7:0] == pwd_fsm_pkg::CMD_EXIT_ENT) begin
        state_ff <= pwd_fsm_pkg::ST_IDLE;
      end else begin
        state_ff <= nxt_state;
      end
    end
  end

  // dwell timer restarts on every state change except the 90h return from read
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      timer_ff <= '0;
    end else if (ce_i) begin
      if (nxt_state != state_ff) timer_ff <= '0;
      else if (!timer_done(timer_ff, T_PPB_CYCLES)) timer_ff <= timer_ff + TW'(1);
    end
  end

  // load bookkeeping: entry sector, previous sector and lane, key shift
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      entry_sa_ff  <= '0;
      prev_sa_ff   <= '0;
      prev_lane_ff <= '0;
      words_ff     <= '0;
      load_key_ff  <= '0;
    end else if (ce_i && cmd_wr) begin
      if (state_ff == pwd_fsm_pkg::ST_IDLE) begin
        entry_sa_ff <= cmd.sector_addr;
        words_ff    <= '0;
      end else if (state_ff == pwd_fsm_pkg::ST_LOAD && nxt_state == pwd_fsm_pkg::ST_LOAD) begin
        prev_sa_ff   <= cmd.sector_addr;
        prev_lane_ff <= cmd.byte_lane_select;
        words_ff     <= words_ff + 4'h1;
        load_key_ff  <= bus_x8_ff ? {cmd.data[7:0], load_key_ff[63:8]} : {cmd.data, load_key_ff[63:16]};
      end
    end
  end

  // stored key is written by host writes to ADDR_KEY_LO and ADDR_KEY_HI; stands in for the array cell
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      secret_key_ff <= '0;
    end else if (ce_i) begin
      if (req && we_i && adr_i == pwd_fsm_pkg::ADDR_KEY_LO) secret_key_ff[31:0] <= dat_i;
      if (req && we_i && adr_i == pwd_fsm_pkg::ADDR_KEY_HI) secret_key_ff[63:32] <= dat_i;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // registers and interrupts

  // control: lock word, bus width; read key
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lock_word_ff <= '0;
      bus_x8_ff    <= 1'b0;
      read_key_ff  <= '0;
      irq_en_ff    <= '0;
    end else if (ce_i && req && we_i) begin
      if (adr_i == pwd_fsm_pkg::ADDR_CTRL && sel_i[0]) lock_word_ff <= dat_i[7:0];
      if (adr_i == pwd_fsm_pkg::ADDR_CTRL && sel_i[1]) bus_x8_ff <= dat_i[8];
      if (adr_i == pwd_fsm_pkg::ADDR_RKEY_LO) read_key_ff[31:0] <= dat_i;
      if (adr_i == pwd_fsm_pkg::ADDR_RKEY_HI) read_key_ff[63:32] <= dat_i;
      if (adr_i == pwd_fsm_pkg::ADDR_IRQ_EN) irq_en_ff <= dat_i[pwd_fsm_pkg::EV_W-1:0];
    end
  end

  // events on state entry
  always_comb begin
    ev = '0;
    ev[pwd_fsm_pkg::EV_DONE] = state_ff == pwd_fsm_pkg::ST_PG_BUSY && nxt_state == pwd_fsm_pkg::ST_IDLE;
    ev[pwd_fsm_pkg::EV_HANG] = state_ff != pwd_fsm_pkg::ST_HANG && nxt_state == pwd_fsm_pkg::ST_HANG;
    ev[pwd_fsm_pkg::EV_PGE]  = state_ff != pwd_fsm_pkg::ST_PGE && nxt_state == pwd_fsm_pkg::ST_PGE;
    ev[pwd_fsm_pkg::EV_SECV] = state_ff != pwd_fsm_pkg::ST_VIOL && nxt_state == pwd_fsm_pkg::ST_VIOL; // R9
  end

  // sticky status: a new event wins over a clear in the same cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_stat_ff <= '0;
    end else if (ce_i) begin
      if (req && we_i && adr_i == pwd_fsm_pkg::ADDR_IRQ_CLR) begin
        irq_stat_ff <= (irq_stat_ff & ~dat_i[pwd_fsm_pkg::EV_W-1:0]) | ev;
      end else begin
        irq_stat_ff <= irq_stat_ff | ev;
      end
    end
  end

  // status word: hang reads 90h, ready bit clear until program time elapses
  function automatic logic [7:0] status_word(input pwd_fsm_pkg::pwd_state_e s, input logic done);
    logic [7:0] w;
    w = 8'h80;
    if (s == pwd_fsm_pkg::ST_HANG) w = done ? pwd_fsm_pkg::SR_HANG : 8'h10; // R6 R8
    else if (s == pwd_fsm_pkg::ST_PG_BUSY || s == pwd_fsm_pkg::ST_VIOL) w = 8'h00; // R8
    else if (s == pwd_fsm_pkg::ST_PGE) w[pwd_fsm_pkg::SR_PGERR_BIT] = 1'b1;
    return w;
  endfunction

  // bus read data and one-cycle ack
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_ff <= 1'b0;
      dat_ff <= '0;
    end else if (ce_i) begin
      ack_ff <= req;
      if (req && !we_i) begin
        case (adr_i)
          pwd_fsm_pkg::ADDR_CTRL:     dat_ff <= {23'h0, bus_x8_ff, lock_word_ff};
          pwd_fsm_pkg::ADDR_STATUS:   dat_ff <= {20'h0, 4'(state_ff),
                                                status_word(state_ff, timer_done(timer_ff, T_PPB_CYCLES))};
          pwd_fsm_pkg::ADDR_IRQ_STAT: dat_ff <= {28'h0, irq_stat_ff};
          pwd_fsm_pkg::ADDR_IRQ_EN:   dat_ff <= {28'h0, irq_en_ff};
          default:                    dat_ff <= '0;
        endcase
      end
    end
  end

  assign ack_o   = ack_ff;
  assign dat_o   = dat_ff;
  assign irq_o   = |(irq_stat_ff & irq_en_ff);
  assign ready_o = !(state_ff == pwd_fsm_pkg::ST_VIOL || state_ff == pwd_fsm_pkg::ST_PG_BUSY); // R9
endmodule

// file: test/pwd_fsm_asserts.sv
// checker for the password command interpreter
// assumes it sees only the top ports and is bound from the testbench top
module pwd_fsm_asserts #(
  parameter int T_PPB_CYCLES = pwd_fsm_pkg::T_PPB_CYC
) (
  // clock, reset, enable
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        ce_i,
  // wishbone slave
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic        we_i,
  input wire logic [7:0]  adr_i,
  input wire logic [3:0]  sel_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic        ack_o,
  // device status
  input wire logic        ready_o,
  input wire logic        irq_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic rd_ack;
  int   low_ff;
  ////////////////////////////////////////////////////////////////
  // master holds address and direction through the ack cycle, so they qualify dat_o
  assign rd_ack = ack_o && !we_i;
  // length of each ready-low run; a stuck busy shows up as an endless run
  always_ff @(posedge clk_i) begin
    if (rst_i || ready_o) low_ff <= 0;
    else low_ff <= low_ff + 1;
  end
  ////////////////////////////////////////////////////////////////
  property p_ack_pulse; ack_o && ce_i |=> !ack_o; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
  property p_ack_lat; cyc_i && stb_i && ce_i && !ack_o |=> ack_o; endproperty
  a_ack_lat: assert property (p_ack_lat) else $error("ack not one cycle after request");
  property p_no_req; !(cyc_i && stb_i) && ce_i |=> !ack_o; endproperty
  a_no_req: assert property (p_no_req) else $error("ack without request");
  property p_reset; disable iff (1'b0) rst_i |=> !ack_o && ready_o && !irq_o && dat_o == 32'h0; endproperty
  a_reset: assert property (p_reset) else $error("outputs not at reset values");
  property p_unmapped; rd_ack && adr_i >= 8'h28 |-> dat_o == 32'h0; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_busy_sr;
    rd_ack && adr_i == pwd_fsm_pkg::ADDR_STATUS && dat_o[11:8] == 4'h4 |-> !dat_o[pwd_fsm_pkg::SR_READY_BIT];
  endproperty
  a_busy_sr: assert property (p_busy_sr) else $error("ready bit set in program busy");
  property p_hang_sr;
    rd_ack && adr_i == pwd_fsm_pkg::ADDR_STATUS && dat_o[11:8] == 4'h7
      |-> dat_o[7:0] == 8'h10 || dat_o[7:0] == pwd_fsm_pkg::SR_HANG;
  endproperty
  a_hang_sr: assert property (p_hang_sr) else $error("hang status word wrong");
  property p_ready_run; low_ff <= T_PPB_CYCLES + 4; endproperty
  a_ready_run: assert property (p_ready_run) else $error("ready low too long");
endmodule

// file: test/pwd_host_model.sv
// host memory controller model: classic wishbone master issuing command cycles
// assumes the testbench calls its tasks just after a rising clock edge
module pwd_host_model (
  // clock and answer
  input  wire logic        clk_i,
  input  wire logic        ack_i,
  input  wire logic [31:0] rd_i,
  // request
  output logic             cyc_o,
  output logic             stb_o,
  output logic             we_o,
  output logic [7:0]       adr_o,
  output logic [3:0]       sel_o,
  output logic [31:0]      dat_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    {cyc_o, stb_o, we_o, adr_o, sel_o, dat_o} = '0;
  end
  ////////////////////////////////////////////////////////////////
  // one bus cycle; a missing ack ends the run rather than hanging it
  task automatic wb(input logic w, input logic [7:0] a, input logic [3:0] s, input logic [31:0] d,
                    output logic [31:0] q);
    int n;
    {cyc_o, stb_o, we_o, adr_o, sel_o, dat_o} <= {2'b11, w, a, s, d};
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_i !== 1'b1 && n < 50);
    if (ack_i !== 1'b1) password_protection_command_fsm_tb.summarize(1);
    q = rd_i;
    {cyc_o, stb_o, we_o} <= 3'b000;
    @(posedge clk_i);
  endtask
  // command cycle: sector in the upper half, command or key data in the lower
  task automatic cmd(input logic [15:0] sec, input logic [15:0] d, input logic [3:0] s = 4'hF);
    logic [31:0] q;
    wb(1'b1, pwd_fsm_pkg::ADDR_CMD, s, {sec, d}, q);
  endtask
  // full unlock on the x16 bus: entry, word count, four key words, start
  task automatic unlock(input logic [15:0] sec, input logic [63:0] key);
    cmd(sec, 16'h0025);
    cmd(sec, 16'h0003);
    for (int i = 0; i < 4; i++) cmd(sec, key[16*i+:16]);
    cmd(sec, 16'h0029);
  endtask
endmodule

// file: test/password_protection_command_fsm_tb.sv
// testbench for the password command interpreter
// assumes the host model drives the bus and the checker is bound here
module password_protection_command_fsm_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int          TP  = 20;
  localparam logic [63:0] KEY = 64'h1234_5678_9ABC_DEF0;
  localparam logic [15:0] SEC = 16'h2800;
  logic        clk_i, rst_i, ce_i, cyc, stb, we, ack, ready, irq;
  logic [7:0]  adr;
  logic [3:0]  sel;
  logic [31:0] wdat, rdat, q;
  int          bad_count, check_count;
  password_protection_command_fsm #(.T_PPB_CYCLES(TP)) uut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
    .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(rdat),
    .ack_o(ack), .ready_o(ready), .irq_o(irq));
  pwd_host_model host (.clk_i(clk_i), .ack_i(ack), .rd_i(rdat), .cyc_o(cyc), .stb_o(stb), .we_o(we),
    .adr_o(adr), .sel_o(sel), .dat_o(wdat));
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  ////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    host.wb(1'b1, a, 4'hF, d, q);
  endtask
  task automatic rd(input logic [7:0] a);
    host.wb(1'b0, a, 4'hF, 32'h0, q);
  endtask
  task automatic state(input logic [3:0] e);
    rd(pwd_fsm_pkg::ADDR_STATUS);
    chk("state", e, q[11:8]);
  endtask
  task automatic summarize(input int hung);
    bad_count += hung;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  // correct key verifies, then falls back to idle well inside the program time
  task automatic t_unlock;
    host.unlock(SEC, KEY);
    repeat (10) @(posedge clk_i);
    state(4'h1);
    $display("done unlock");
  endtask
  // x8 bus: eight byte cycles load the same key; a wrong count would end in program error
  task automatic t_unlock8;
    wr(pwd_fsm_pkg::ADDR_CTRL, 32'h100);
    host.cmd(SEC, 16'h0025);
    host.cmd(SEC, 16'h0003);
    for (int i = 0; i < 8; i++) host.cmd(SEC, {8'h00, KEY[8*i+:8]});
    host.cmd(SEC, 16'h0029);
    repeat (10) @(posedge clk_i);
    state(4'h1);
    wr(pwd_fsm_pkg::ADDR_CTRL, 32'h000);
    $display("done unlock x8");
  endtask
  // wrong key hangs; interrupt is masked, unmasked and cleared
  task automatic t_hang;
    wr(pwd_fsm_pkg::ADDR_IRQ_EN, 32'h2);
    host.unlock(SEC, ~KEY);
    state(4'h7);
    chk("status", 8'h10, q[7:0]);
    chk("irq", 1'b1, irq);
    repeat (TP + 4) @(posedge clk_i);
    rd(pwd_fsm_pkg::ADDR_STATUS);
    chk("status", pwd_fsm_pkg::SR_HANG, q[7:0]);
    wr(pwd_fsm_pkg::ADDR_IRQ_EN, 32'h0);
    chk("irq", 1'b0, irq);
    rd(pwd_fsm_pkg::ADDR_IRQ_STAT);
    chk("irq_stat", 32'h2, q);
    wr(pwd_fsm_pkg::ADDR_IRQ_EN, 32'h2);
    chk("irq", 1'b1, irq);
    wr(pwd_fsm_pkg::ADDR_IRQ_CLR, 32'h2);
    chk("irq", 1'b0, irq);
    host.cmd(SEC, 16'h00F0);
    state(4'h1);
    $display("done hang");
  endtask
  // load faults: mode 0 sector change, 1 lane change, 2 early start, 3 first sector not the entry one
  task automatic t_pge(input int mode);
    host.cmd(SEC, 16'h0025);
    host.cmd(SEC, 16'h0003);
    host.cmd(mode == 3 ? 16'h3000 : SEC, KEY[15:0]);
    if (mode == 0) host.cmd(16'h3000, KEY[31:16]);
    else if (mode == 1) host.cmd(SEC, KEY[31:16], 4'h3);
    else if (mode == 2) host.cmd(SEC, 16'h0029);
    state(4'hD);
    rd(pwd_fsm_pkg::ADDR_IRQ_STAT);
    chk("pge_event", 1'b1, q[pwd_fsm_pkg::EV_PGE]);
    repeat (TP + 4) @(posedge clk_i);
    host.cmd(SEC, 16'h00F0);
    state(4'h1);
    wr(pwd_fsm_pkg::ADDR_IRQ_CLR, 32'hF);
    $display("done load fault %0d", mode);
  endtask
  // programming allowed with lock bit 2 set; busy for the program time
  task automatic t_prog;
    wr(pwd_fsm_pkg::ADDR_CTRL, 32'h04);
    host.cmd(SEC, 16'h00A0);
    state(4'h5);
    host.cmd(SEC, 16'h0000);
    state(4'h4);
    chk("sr7", 1'b0, q[7]);
    chk("ready", 1'b0, ready);
    repeat (TP + 4) @(posedge clk_i);
    state(4'h1);
    chk("ready", 1'b1, ready);
    rd(pwd_fsm_pkg::ADDR_IRQ_STAT);
    chk("done_event", 1'b1, q[pwd_fsm_pkg::EV_DONE]);
    wr(pwd_fsm_pkg::ADDR_IRQ_CLR, 32'hF);
    $display("done program");
  endtask
  // lock bit 2 clear, bit 5 set: not protected, so programming is a violation
  task automatic t_viol;
    wr(pwd_fsm_pkg::ADDR_CTRL, 32'h20);
    host.cmd(SEC, 16'h00A0);
    host.cmd(SEC, 16'h0000);
    chk("ready", 1'b0, ready);
    // clock enable low freezes the ready drop; the run stays short of the busy bound
    ce_i <= 1'b0;
    repeat (10) @(posedge clk_i);
    ce_i <= 1'b1;
    chk("ready", 1'b0, ready);
    repeat (8) @(posedge clk_i);
    state(4'h1);
    chk("ready", 1'b1, ready);
    rd(pwd_fsm_pkg::ADDR_IRQ_STAT);
    chk("secv_event", 1'b1, q[pwd_fsm_pkg::EV_SECV]);
    wr(pwd_fsm_pkg::ADDR_IRQ_CLR, 32'hF);
    $display("done violation");
  endtask
  // read protected idle ignores program; mode walk through read and exit
  task automatic t_cmds;
    logic [7:0] cm [5];
    logic [3:0] ex [5];
    cm = '{8'hF0, 8'h90, 8'h90, 8'h00, 8'h90};
    ex = '{4'h0, 4'h1, 4'hC, 4'h0, 4'h1};
    wr(pwd_fsm_pkg::ADDR_CTRL, 32'h00);
    host.cmd(SEC, 16'h00A0);
    state(4'h1);
    // matching read key lifts the protection; the confirm then trips the violation path
    wr(pwd_fsm_pkg::ADDR_RKEY_LO, KEY[31:0]);
    wr(pwd_fsm_pkg::ADDR_RKEY_HI, KEY[63:32]);
    host.cmd(SEC, 16'h00A0);
    state(4'h5);
    host.cmd(SEC, 16'h0000);
    repeat (8) @(posedge clk_i);
    state(4'h1);
    for (int i = 0; i < 5; i++) begin
      host.cmd(SEC, {8'h00, cm[i]});
      state(ex[i]);
    end
    wr(8'h40, 32'hFFFF_FFFF);
    rd(8'h40);
    chk("unmapped", 32'h0, q);
    $display("done commands");
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    rst_i = 1'b1;
    ce_i = 1'b1;
    bad_count = 0;
    check_count = 0;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    state(4'h1);
    chk("ready", 1'b1, ready);
    wr(pwd_fsm_pkg::ADDR_KEY_LO, KEY[31:0]);
    wr(pwd_fsm_pkg::ADDR_KEY_HI, KEY[63:32]);
    t_unlock();
    t_unlock8();
    t_hang();
    for (int m = 0; m < 4; m++) t_pge(m);
    t_prog();
    t_viol();
    t_cmds();
    summarize(0);
  end
endmodule
bind password_protection_command_fsm pwd_fsm_asserts #(.T_PPB_CYCLES(T_PPB_CYCLES)) chk_i (.clk_i(clk_i),
  .rst_i(rst_i), .ce_i(ce_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
  .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .ready_o(ready_o), .irq_o(irq_o));
